// ### hw/smbus_port_pkg.sv
// Shared constants and types for the SMBus register port and its host end
package smbus_port_pkg;

    typedef logic [7:0] byte_type;
    typedef logic [6:0] addr_type;

    // ----------------------------------------------------------------
    // Clock and link timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_KHZ = 200000;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
    // Ready for a new START well inside this limit, since reset follows at once
    localparam int TIMEOUT_MAX_MS = 35;
    localparam int TIMEOUT_WIDTH = 23;

    // ----------------------------------------------------------------
    // Addressing and bus fields
    // ----------------------------------------------------------------
    localparam addr_type ADDR_DEFAULT = 7'h2e;
    localparam logic [4:0] ADDR_STRAP_HI = 5'h0b;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam byte_type UNDEF_READ = 8'h00;
    localparam byte_type RX_RELEASE = 8'hff;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

// ### hw/smbus_port_if.sv
// Two-wire SMBus carrier joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none

interface smbus_port_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    wire logic scl;
    wire logic sda;

    // Open-drain wired AND with pull-ups
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

`default_nettype wire

// ### hw/smbus_slave_port.sv
// SMBus slave register port: strap addressing, Write Byte and Read Byte
`timescale 1ns/1ps
`default_nettype none

module smbus_slave_port #(
    parameter int TIMEOUT_LIMIT = smbus_port_pkg::TIMEOUT_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    smbus_port_if.device bus,
    input wire logic i_fan_drive_out_3,
    output logic o_fan_drive_out_3,
    output logic o_fan_drive_out_3_oe,
    output logic o_fan_drive_out_2,
    output logic o_fan_drive_out_2_oe,
    input wire logic i_fan_speed_in_3,
    output logic o_fan_speed_in_3,
    output logic o_fan_speed_in_3_oe,
    input wire logic i_fan_speed_in_4,
    input wire logic i_pwm_2,
    input wire logic i_pwm_3,
    input wire logic i_alert_n,
    input wire logic i_alert_enable,
    input wire logic i_alert_on_speed_3,
    output logic o_speed_3,
    output logic o_speed_4,
    output logic o_strap_mode,
    output smbus_port_pkg::byte_type o_reg_index,
    output smbus_port_pkg::byte_type o_reg_wdata,
    output logic o_reg_write,
    output logic o_reg_read,
    input wire smbus_port_pkg::byte_type i_reg_rdata,
    input wire logic i_reg_defined
);
    import smbus_port_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_A = 4'h3,
        ST_INDEX = 4'h2,
        ST_ACK_I = 4'h6,
        ST_DATA = 4'h7,
        ST_ACK_D = 4'h5,
        ST_WAIT_STOP = 4'h4,
        ST_ADDR_R = 4'hc,
        ST_ACK_R = 4'hd,
        ST_SEND = 4'hf,
        ST_HOST_ACK = 4'he,
        ST_IGNORE = 4'ha
    } state_type;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic scl_d;
    logic sda_d;

    // Two flops for every pin; only the second stage feeds logic
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            pin_meta <= {bus.scl, bus.sda, i_fan_drive_out_3, i_fan_speed_in_4, i_fan_speed_in_3};
            pin_sync <= pin_meta;
            scl_d <= pin_sync[4];
            sda_d <= pin_sync[3];
        end
    end

    wire scl_s = pin_sync[4];
    wire sda_s = pin_sync[3];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

    // ------------------------------------------------------------
    // Strap capture and address selection
    // ------------------------------------------------------------
    logic [1:0] strap_wait;
    logic strap_done;
    logic strap_mode;
    logic addr_latched;
    logic sel_latched;

    // Strap caught after release, once the synchroniser holds real levels
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            strap_mode <= 1'b0;
        end else if (!strap_done) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == STRAP_SETTLE) begin
                strap_done <= 1'b1;
                strap_mode <= ~pin_sync[2];
            end
        end
    end

    state_type state;
    state_type next_state;
    logic [3:0] bit_cnt;
    byte_type shift;
    logic [TIMEOUT_WIDTH-1:0] low_cnt;

    wire sel_now = addr_latched ? sel_latched : pin_sync[1];
    wire addr_type own_addr = strap_mode ? {ADDR_STRAP_HI, 1'b0, sel_now} : ADDR_DEFAULT;
    wire addr_hit = strap_done && (shift[7:1] == own_addr);
    wire byte_done = (bit_cnt == BYTE_BITS) & scl_fall;
    wire upper_hit = byte_done && (state == ST_ADDR || state == ST_ADDR_R) && (shift[7:3] == ADDR_STRAP_HI);
    wire timeout = (low_cnt >= TIMEOUT_LIMIT[TIMEOUT_WIDTH-1:0] - 23'h1);
    wire repeat_start = (state == ST_DATA) && (bit_cnt == 4'h1);

    // Select level frozen on first address whose upper five bits match ADDR_STRAP_HI; later strap moves ignored
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            addr_latched <= 1'b0;
            sel_latched <= 1'b0;
        end else if (strap_mode && !addr_latched && upper_hit) begin
            addr_latched <= 1'b1;
            sel_latched <= pin_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Protocol sequencer
    // ------------------------------------------------------------
    // STOP and timeout win over everything; any START restarts decoding
    always_comb begin
        next_state = state;
        if (stop_cond || timeout) begin
            next_state = ST_IDLE;
        end else if (start_cond) begin
            next_state = repeat_start ? ST_ADDR_R : ST_ADDR;
        end else begin
            case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_ADDR: if (byte_done) next_state = (addr_hit && shift[0] == RW_WRITE) ? ST_ACK_A : ST_IGNORE;
                ST_ACK_A: if (scl_fall) next_state = ST_INDEX;
                ST_INDEX: if (byte_done) next_state = ST_ACK_I;
                ST_ACK_I: if (scl_fall) next_state = ST_DATA;
                ST_DATA: if (byte_done) next_state = ST_ACK_D;
                ST_ACK_D: if (scl_fall) next_state = ST_WAIT_STOP;
                // A STOP also begins with a clock rise; only a full extra clock pulse is refused
                ST_WAIT_STOP: if (scl_fall) next_state = ST_IGNORE;
                ST_ADDR_R: if (byte_done) next_state = (addr_hit && shift[0] == RW_READ) ? ST_ACK_R : ST_IGNORE;
                ST_ACK_R: if (scl_fall) next_state = ST_SEND;
                ST_SEND: if (scl_fall && bit_cnt == 4'h7) next_state = ST_HOST_ACK;
                ST_HOST_ACK: if (scl_rise) next_state = ST_IGNORE;
                ST_IGNORE: next_state = ST_IGNORE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Clock-low watchdog, only while a transfer is open
    always_ff @(posedge i_core_clk) begin
        if (i_reset || scl_s || state == ST_IDLE) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + 23'h1;
        end
    end

    wire receiving = (state == ST_ADDR) || (state == ST_INDEX) || (state == ST_DATA) || (state == ST_ADDR_R);
    wire load_read = (state == ST_ACK_R) && (next_state == ST_SEND);
    wire byte_type read_byte = i_reg_defined ? i_reg_rdata : UNDEF_READ;

    // Shift register: sample on rise when receiving, shift out on fall when sending
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            bit_cnt <= 4'h0;
            shift <= 8'h00;
        end else if (load_read) begin
            bit_cnt <= 4'h0;
            shift <= read_byte;
        end else if (state != next_state) begin
            bit_cnt <= 4'h0;
        end else if (receiving && scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift <= {shift[6:0], sda_s};
        end else if (state == ST_SEND && scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift <= {shift[6:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Register access strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_index <= 8'h00;
            o_reg_wdata <= 8'h00;
            o_reg_write <= 1'b0;
            o_reg_read <= 1'b0;
        end else begin
            if (state == ST_INDEX && byte_done) o_reg_index <= shift;
            if (state == ST_DATA && byte_done) o_reg_wdata <= shift;
            // Commit only on STOP right after the acked data byte
            o_reg_write <= (state == ST_WAIT_STOP) && stop_cond && i_reg_defined;
            o_reg_read <= load_read;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    wire ack_slot = (state == ST_ACK_A) || (state == ST_ACK_I) || (state == ST_ACK_D) || (state == ST_ACK_R);
    wire alert_low = i_alert_enable & ~i_alert_n;

    // Registered enables keep the open-drain pins glitch free
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            bus.dev_sda_oe <= 1'b0;
            o_fan_drive_out_2_oe <= 1'b0;
            o_fan_speed_in_3_oe <= 1'b0;
            o_fan_drive_out_3_oe <= 1'b0;
        end else begin
            bus.dev_sda_oe <= ack_slot || (state == ST_SEND && !shift[7]);
            o_fan_drive_out_2_oe <= i_alert_on_speed_3 ? ~i_pwm_2 : (alert_low | ~i_alert_enable & ~i_pwm_2);
            o_fan_speed_in_3_oe <= i_alert_on_speed_3 & alert_low;
            // Drive-3 pin stays quiet in strap mode so the pull-down reads true
            o_fan_drive_out_3_oe <= strap_done & ~strap_mode & ~i_pwm_3;
        end
    end

    // Open-drain pins only ever pull low
    assign bus.dev_sda_o = 1'b0;
    assign o_fan_drive_out_2 = 1'b0;
    assign o_fan_speed_in_3 = 1'b0;
    assign o_fan_drive_out_3 = 1'b0;
    assign o_speed_3 = pin_sync[0] & ~(i_alert_on_speed_3 & i_alert_enable);
    assign o_speed_4 = pin_sync[1] & ~strap_mode;
    assign o_strap_mode = strap_mode;

endmodule

`default_nettype wire

// ### hw/smbus_host_port.sv
// SMBus host end issuing Write Byte and Read Byte transfers
`timescale 1ns/1ps
`default_nettype none

module smbus_host_port #(
    parameter int QUARTER = smbus_port_pkg::QUARTER_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    smbus_port_if.host bus,
    input wire logic i_request,
    input wire logic i_read,
    input wire smbus_port_pkg::addr_type i_slave_addr,
    input wire smbus_port_pkg::byte_type i_index,
    input wire smbus_port_pkg::byte_type i_wdata,
    output logic o_ready,
    output logic o_done,
    output logic o_nacked,
    output smbus_port_pkg::byte_type o_rdata
);
    import smbus_port_pkg::*;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_START = 2'h1,
        HS_BYTE = 2'h3,
        HS_STOP = 2'h2
    } host_state_type;

    // ------------------------------------------------------------
    // Quarter-bit divider and data sampling
    // ------------------------------------------------------------
    logic [15:0] div_cnt;
    logic [1:0] quarter;
    logic sda_meta;
    logic sda_sync;
    host_state_type state;
    wire tick = (div_cnt == QUARTER[15:0] - 16'h1);

    // Divider idles at zero so every transfer starts on a clean phase
    always_ff @(posedge i_core_clk) begin
        if (i_reset || state == HS_IDLE || tick) begin
            div_cnt <= 16'h0;
        end else begin
            div_cnt <= div_cnt + 16'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            sda_meta <= bus.sda;
            sda_sync <= sda_meta;
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    logic [1:0] step;
    logic [3:0] bit_idx;
    logic rd;
    addr_type addr;
    byte_type index;
    byte_type wdata;
    byte_type rx;

    // Step 0 address+write, 1 index, 2 data or address+read, 3 receive
    wire byte_type tx = (step == 2'h0) ? {addr, RW_WRITE} :
                        (step == 2'h1) ? index :
                        (step == 2'h2) ? (rd ? {addr, RW_READ} : wdata) : RX_RELEASE;
    wire last_bit = (bit_idx == BYTE_BITS);
    wire data_low = ~last_bit & ~tx[3'h7 - bit_idx[2:0]];
    wire last_byte = rd ? (step == 2'h3) : (step == 2'h2);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state <= HS_IDLE;
            quarter <= 2'h0;
            step <= 2'h0;
            bit_idx <= 4'h0;
            rd <= 1'b0;
            addr <= 7'h00;
            index <= 8'h00;
            wdata <= 8'h00;
            rx <= 8'h00;
            o_rdata <= 8'h00;
            o_done <= 1'b0;
            o_nacked <= 1'b0;
            bus.host_scl_oe <= 1'b0;
            bus.host_sda_oe <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (state == HS_IDLE) begin
                if (i_request) begin
                    state <= HS_START;
                    quarter <= 2'h0;
                    step <= 2'h0;
                    rd <= i_read;
                    addr <= i_slave_addr;
                    index <= i_index;
                    wdata <= i_wdata;
                    o_nacked <= 1'b0;
                end
            end else if (tick) begin
                quarter <= quarter + 2'h1;
                case (state)
                    // Release data, raise clock, pull data low, pull clock low
                    HS_START: begin
                        case (quarter)
                            2'h0: bus.host_sda_oe <= 1'b0;
                            2'h1: bus.host_scl_oe <= 1'b0;
                            2'h2: bus.host_sda_oe <= 1'b1;
                            default: begin
                                bus.host_scl_oe <= 1'b1;
                                state <= HS_BYTE;
                                bit_idx <= 4'h0;
                            end
                        endcase
                    end
                    // Data set while clock low, sampled in the high half
                    HS_BYTE: begin
                        case (quarter)
                            2'h0: bus.host_sda_oe <= data_low;
                            2'h1: bus.host_scl_oe <= 1'b0;
                            2'h2: begin
                                if (!last_bit) rx <= {rx[6:0], sda_sync};
                                if (last_bit && step != 2'h3 && sda_sync) o_nacked <= 1'b1;
                            end
                            default: begin
                                bus.host_scl_oe <= 1'b1;
                                bit_idx <= bit_idx + 4'h1;
                                if (last_bit) begin
                                    bit_idx <= 4'h0;
                                    step <= step + 2'h1;
                                    if (o_nacked || last_byte) begin
                                        state <= HS_STOP;
                                    end else if (rd && step == 2'h1) begin
                                        state <= HS_START;
                                    end
                                end
                            end
                        endcase
                    end
                    // Data low, clock high, data released
                    HS_STOP: begin
                        case (quarter)
                            2'h0: bus.host_sda_oe <= 1'b1;
                            2'h1: bus.host_scl_oe <= 1'b0;
                            2'h2: bus.host_sda_oe <= 1'b0;
                            default: begin
                                state <= HS_IDLE;
                                o_done <= 1'b1;
                                o_rdata <= rx;
                            end
                        endcase
                    end
                    default: state <= HS_IDLE;
                endcase
            end
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign o_ready = (state == HS_IDLE);

endmodule

`default_nettype wire

// ### tb/smbus_port_monitor.sv
// Wire-level checker for the SMBus link between host end and register port
`timescale 1ns/1ps
`default_nettype none

module smbus_port_monitor (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe
);
    logic scl_q;
    logic [7:0] since_fall;
    wire logic scl_fell = scl_q & ~scl;

    // ----------------------------------------------------------------
    // Cycles since the last clock fall
    // ----------------------------------------------------------------
    // Saturates so a long idle bus never wraps back into the legal window
    always_ff @(posedge i_core_clk) begin
        scl_q <= scl;
        if (i_reset || scl_fell) begin
            since_fall <= 8'h00;
        end else if (since_fall != 8'hff) begin
            since_fall <= since_fall + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Link properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    a_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> host_sda_oe)
        else $error("START made without host pulling data");
    a_start_dev_quiet: assert property (scl && $past(scl) && $fell(sda) |-> ##1 !dev_sda_oe [*4])
        else $error("device pulls data after START");
    a_stop_dev_quiet: assert property (scl && $past(scl) && $rose(sda) |-> !dev_sda_oe [*8])
        else $error("device pulls data after STOP");
    a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device changed data while clock high");
    a_dev_answer_delay: assert property ($changed(dev_sda_oe) |-> since_fall >= 8'h01 && since_fall <= 8'h08)
        else $error("device data change not just after clock fall");
    // Both may pull briefly while the clock is low; the sampled half must belong to the device alone
    a_host_yields_sda: assert property (scl && dev_sda_oe |-> !host_sda_oe)
        else $error("host and device drive data together");
    a_dev_pull_bounded: assert property ($rose(dev_sda_oe) |-> ##[1:1000] !dev_sda_oe)
        else $error("device holds data low too long");
    a_high_sda_steady: assert property ($rose(scl) |-> $stable(sda) [*8])
        else $error("data moved early in clock high phase");

    c_dev_answers: cover property ($rose(dev_sda_oe));
    c_start_seen: cover property (scl && $fell(sda));
    c_stop_seen: cover property (scl && $rose(sda));
endmodule

`default_nettype wire

// ### tb/smbus_slave_register_port_tb.sv
// Self-checking bench joining the SMBus host end to the register port
`timescale 1ns/1ps
`default_nettype none

module smbus_slave_register_port_tb;
    import smbus_port_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, request = 1'b0, rd = 1'b0;
    addr_type slave_addr = ADDR_DEFAULT;
    byte_type index = 8'h00, wdata = 8'h00, reg_rdata, rdata, reg_index, reg_wdata;
    logic drive3 = 1'b1, speed3 = 1'b0, speed4 = 1'b0, fan_drive_out_2 = 1'b1, fan_drive_out_3 = 1'b1;
    logic alert_n = 1'b1, alert_en = 1'b0, alert_s3 = 1'b0;
    logic ready, done, nacked, strap_mode, reg_write, reg_defined, d2_oe, s3_oe, d3_oe, spd3, spd4;
    byte_type regs [16];
    int num_errors = 0, total_checks = 0, cycles = 0;

    // ----------------------------------------------------------------
    // Both ends, the link and its checker
    // ----------------------------------------------------------------
    smbus_port_if bus ();
    smbus_host_port #(.QUARTER(20)) i_smbus_host_port (.i_core_clk(core_clk), .i_reset(reset), .bus(bus),
        .i_request(request), .i_read(rd), .i_slave_addr(slave_addr), .i_index(index), .i_wdata(wdata),
        .o_ready(ready), .o_done(done), .o_nacked(nacked), .o_rdata(rdata));
    smbus_slave_port #(.TIMEOUT_LIMIT(400)) i_smbus_slave_port (.i_core_clk(core_clk), .i_reset(reset),
        .bus(bus), .i_fan_drive_out_3(drive3), .o_fan_drive_out_3(), .o_fan_drive_out_3_oe(d3_oe),
        .o_fan_drive_out_2(), .o_fan_drive_out_2_oe(d2_oe), .i_fan_speed_in_3(speed3), .o_fan_speed_in_3(),
        .o_fan_speed_in_3_oe(s3_oe), .i_fan_speed_in_4(speed4), .i_pwm_2(fan_drive_out_2), .i_pwm_3(fan_drive_out_3),
        .i_alert_n(alert_n), .i_alert_enable(alert_en), .i_alert_on_speed_3(alert_s3), .o_speed_3(spd3),
        .o_speed_4(spd4), .o_strap_mode(strap_mode), .o_reg_index(reg_index), .o_reg_wdata(reg_wdata),
        .o_reg_write(reg_write), .o_reg_read(), .i_reg_rdata(reg_rdata), .i_reg_defined(reg_defined));
    smbus_port_monitor i_smbus_port_monitor (.i_core_clk(core_clk), .i_reset(reset), .scl(bus.scl),
        .sda(bus.sda), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));

    // Sixteen defined registers; anything above reads as undefined
    assign reg_defined = (reg_index < 8'h10);
    assign reg_rdata = regs[reg_index[3:0]];
    always @(posedge core_clk) if (reg_write === 1'b1) regs[reg_index[3:0]] <= reg_wdata;

    initial forever #2.5 core_clk = ~core_clk;

    // Hang guard: all transfers together need well under this
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input byte_type exp, input byte_type got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Mode strap counts only at power-up and the select level freezes on the first address, so each mode needs its own reset
    task automatic do_reset(input logic strap_off, input logic sel);
        @(posedge core_clk);
        drive3 <= strap_off;
        speed4 <= sel;
        reset <= 1'b1;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic xfer(input logic r, input addr_type a, input byte_type i, input byte_type w);
        int n;
        n = 0;
        @(posedge core_clk);
        rd <= r;
        slave_addr <= a;
        index <= i;
        wdata <= w;
        request <= 1'b1;
        @(posedge core_clk);
        request <= 1'b0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 6000);
        check("transfer done", 8'h01, {7'h00, done});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_default;
        do_reset(1'b1, 1'b1);
        check("strap mode", 8'h00, {7'h00, strap_mode});
        @(posedge core_clk);
        fan_drive_out_3 <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("drive 3 and speed 4 pins", 8'h03, {6'h00, d3_oe, spd4});
        xfer(RW_WRITE, ADDR_DEFAULT, 8'h03, 8'ha5);
        check("write ack", 8'h00, {7'h00, nacked});
        check("stored byte", 8'ha5, regs[3]);
        xfer(RW_WRITE, ADDR_DEFAULT, 8'h04, 8'h5a);
        xfer(RW_READ, ADDR_DEFAULT, 8'h03, 8'h00);
        check("read byte", 8'ha5, rdata);
        xfer(RW_WRITE, 7'h2c, 8'h03, 8'h11);
        check("wrong address nack", 8'h01, {7'h00, nacked});
        check("untouched byte", 8'ha5, regs[3]);
        check("neighbour byte", 8'h5a, regs[4]);
        $display("test_default finished");
    endtask

    task automatic test_strap;
        do_reset(1'b0, 1'b0);
        check("strap mode", 8'h01, {7'h00, strap_mode});
        xfer(RW_WRITE, 7'h2c, 8'h06, 8'h21);
        check("select low ack", 8'h00, {7'h00, nacked});
        do_reset(1'b0, 1'b1);
        check("strap pins quiet", 8'h00, {6'h00, d3_oe, spd4});
        xfer(RW_WRITE, ADDR_DEFAULT, 8'h05, 8'h3c);
        check("default refused", 8'h01, {7'h00, nacked});
        xfer(RW_WRITE, 7'h2d, 8'h05, 8'h3c);
        check("select high ack", 8'h00, {7'h00, nacked});
        @(posedge core_clk);
        speed4 <= 1'b0;
        xfer(RW_READ, 7'h2d, 8'h05, 8'h00);
        check("latched read", 8'h3c, rdata);
        xfer(RW_WRITE, 7'h2c, 8'h05, 8'h77);
        check("late select nack", 8'h01, {7'h00, nacked});
        check("kept byte", 8'h3c, regs[5]);
        $display("test_strap finished");
    endtask

    task automatic test_undefined;
        xfer(RW_WRITE, 7'h2d, 8'h80, 8'h99);
        check("undefined write ack", 8'h00, {7'h00, nacked});
        check("no stray store", 8'hc3, regs[0]);
        xfer(RW_READ, 7'h2d, 8'h80, 8'h00);
        check("undefined read", UNDEF_READ, rdata);
        $display("test_undefined finished");
    endtask

    // Speed-3 pin held high so the alert route visibly masks its reading
    task automatic test_alert;
        @(posedge core_clk);
        speed3 <= 1'b1;
        alert_en <= 1'b1;
        alert_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check("alert on drive 2", 8'h05, {5'h00, spd3, s3_oe, d2_oe});
        @(posedge core_clk);
        alert_s3 <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check("alert on speed 3", 8'h02, {5'h00, spd3, s3_oe, d2_oe});
        $display("test_alert finished");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        foreach (regs[k]) regs[k] = 8'hc3;
        test_default();
        test_strap();
        test_undefined();
        test_alert();
        tally_and_finish();
    end
endmodule

`default_nettype wire
